// file: adc_ctrl_checker_asserts.sv
// Port assertions for the converter trigger and input control block
`timescale 1ns/10ps
module adc_ctrl_checker (
	input wire logic       mclk,
	input wire logic       srst,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       conv_start,
	input wire logic       timer_overflow,
	input wire logic       conv_sampling,
	input wire logic       conversion_busy,
	input wire logic       conv_done,
	input wire logic       ref_sel_supply,
	input wire logic       ref_sel_pin,
	input wire logic       ref_sel_amp,
	input wire logic       amp_ref_pin_connect,
	input wire logic [1:0] gain_amp_input_sel,
	input wire logic [7:0] an_pin_connect,
	input wire logic [7:0] int_sig_connect
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	rdata_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data without a read");
	ref_onehot_a: assert property ($onehot({ref_sel_supply, ref_sel_pin, ref_sel_amp}))
		else $error("reference routing not one-hot");
	ref_pin_off_a: assert property (amp_ref_pin_connect |->
		ref_sel_amp && $past(gain_amp_input_sel) == 2'h0)
		else $error("reference pin left connected");
	route_excl_a: assert property (an_pin_connect == 8'h00 || int_sig_connect == 8'h00)
		else $error("pin tied to internal signal");
	route_single_a: assert property ($onehot0(an_pin_connect) && $onehot0(int_sig_connect))
		else $error("more than one input routed");
	conv_take_a: assert property (conv_start && !conversion_busy |=> conversion_busy && conv_sampling)
		else $error("conversion start not taken");
	conv_end_a: assert property (conv_done |-> !conversion_busy && $past(conversion_busy))
		else $error("done without end of busy");
	sample_busy_a: assert property (conv_sampling |-> conversion_busy)
		else $error("sampling outside a conversion");
	ovf_pulse_a: assert property (timer_overflow |=> !timer_overflow)
		else $error("overflow pulse too long");
endmodule
bind adc_trigger_input_ctrl adc_ctrl_checker adc_ctrl_checker_i (.mclk, .srst, .rd, .rdata,
	.conv_start, .timer_overflow, .conv_sampling, .conversion_busy, .conv_done, .ref_sel_supply,
	.ref_sel_pin, .ref_sel_amp, .amp_ref_pin_connect, .gain_amp_input_sel, .an_pin_connect,
	.int_sig_connect);

// file: adc_ctrl_defines.vh
// Constants for the converter trigger timer and input selection block
// Summary of operation
// - Trigger select 01: over-voltage rising edge sets run; overflow clears run.
// - Trigger select 10: start bit rise sets run, start bit fall clears run.
// - Counter takes preload while stopped; while running reloads only at overflow.
// - Edge trigger enable 0: over-voltage edges do not touch run.
// - Trigger select 01, edge trigger enable 1 and not busy: over-voltage rising edge sets run.
// - Prescale bit picks timer tick of clock divided by 4 or 8.
// - Low preload write fills buffer; high write commits high byte and buffer.
// - High read returns high byte and latches low; low read returns buffer.
// - Preload is 16 bits as high and low bytes, both read/write, reset zero.
// - Reference select 00 supply, 01 external pin, 10/11 amplifier output.
// - Amplifier enable, two-bit gain and two-bit input select are provided.
// - Internal reference selected disconnects the external reference pins.
// - Analog pin mode disables other functions, pull-up and direction control.
// - Single mode: sources 0000,0100,1100-1111 use pin; channel 0-7, 8-15 floating.
// - Single mode internal sources map to supply, fractions, amplifier, ground, sensor.
// - Dual mode source bit 0 internal, 1 pin; codes 8-15 float.
// - Dual mode internal codes map to supply, fractions, amplifier, ground, sensor.
// - Internal signal selected means the external channel is disconnected.
// - Converter clock is system clock undivided or divided per three-bit select.
// - Clock select codes 0 to 7 divide by 1,2,4,...,128.
// - A conversion lasts 16 converter clocks: 4 sampling, 12 converting.
// - Running timer counts up from preload to FFFF; software only clears run.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define REG_TIMER_CTRL   4'h0
`define REG_PRELOAD_HI   4'h1
`define REG_PRELOAD_LO   4'h2
`define REG_TRIG_CFG     4'h3
`define REG_AUTO_START   4'h4
`define REG_REF_AMP      4'h5
`define REG_INPUT_SEL    4'h6
`define REG_CLK_SEL      4'h7
`define REG_CH1_SEL      4'h8
`define REG_CH2_SEL      4'h9
`define REG_STATUS       4'hA
`define REG_PIN_ANALOG   4'hB
`define TC_RUN_BIT       4
`define TC_EXT_BIT       1
`define TC_PSC_BIT       0
`define TRIG_DUAL_BIT    5
`define AUTO_GO_BIT      7
`define AMP_EN_BIT       7
`define CH_SRC_BIT       4
`define TRIG_OVP         2'h1
`define TRIG_START       2'h2
`define REF_SUPPLY       2'h0
`define REF_PIN          2'h1
`define AMP_IN_PIN       2'h0
`define PRE_DIV4_LAST    3'h3
`define PRE_DIV8_LAST    3'h7
`define SAMPLE_TICKS     5'h04
`define CONV_TICKS       5'h10
`define TIMER_FULL       16'hFFFF
`define RESET_BYTE       8'h00
`define SIG_AVDD         3'h0
`define SIG_AVDD2        3'h1
`define SIG_AVDD4        3'h2
`define SIG_VVR          3'h3
`define SIG_VVR2         3'h4
`define SIG_VVR4         3'h5
`define SIG_AVSS         3'h6
`define SIG_TSO          3'h7
`endif

// file: adc_trigger_input_ctrl.v
// Converter trigger timer, reference and input selection, and clock divider
`timescale 1ns/10ps
`include "adc_ctrl_defines.vh"
module adc_trigger_input_ctrl (
	input  wire       mclk,
	input  wire       srst,
	input  wire [3:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	input  wire       overvoltage_event,
	input  wire       conv_start,
	input  wire       conv_channel,
	output reg        timer_overflow,
	output reg        conv_clk_tick,
	output reg        conv_sampling,
	output reg        conversion_busy,
	output reg        conv_done,
	output reg        ref_sel_supply,
	output reg        ref_sel_pin,
	output reg        ref_sel_amp,
	output reg        amp_ref_pin_connect,
	output reg        gain_amp_enable,
	output reg  [1:0] gain_amp_gain_sel,
	output reg  [1:0] gain_amp_input_sel,
	output reg  [7:0] an_pin_connect,
	output reg  [7:0] int_sig_connect,
	output reg  [7:0] pin_analog_mode
);
	reg  [7:0]  preload_high_byte;
	reg  [7:0]  preload_low_byte;
	reg  [7:0]  low_buf_r;
	reg  [15:0] count_r;
	reg  [2:0]  pre_r;
	reg         timer_run_flag;
	reg         ext_edge_trigger_en;
	reg         timer_prescale_sel;
	reg  [1:0]  auto_trigger_source_sel;
	reg         dual_channel_mode_en;
	reg         auto_conv_start_bit;
	reg  [1:0]  reference_source_sel;
	reg  [7:0]  input_sel_r;
	reg  [2:0]  conv_clock_div_sel;
	reg  [4:0]  ch1_sel_r;
	reg  [4:0]  ch2_sel_r;
	reg  [7:0]  pin_analog_r;
	reg  [6:0]  div_r;
	reg  [4:0]  phase_r;
	reg         tick_nxt;
	reg         ovf_nxt;
	reg         ext_nxt;
	reg  [2:0]  chan_nxt;
	reg  [2:0]  sig_nxt;
	reg         use_pin;
	reg  [3:0]  src;
	reg  [4:0]  dsel;
	reg  [6:0]  div_last;
	reg  [2:0]  pre_last;

	wire        ovp_sync;
	wire        ovp_rise;
	wire        start_rise;
	wire        start_fall;
	wire [7:0]  pin_onehot;
	wire [7:0]  sig_onehot;
	wire wr_ctrl    = wr && (addr == `REG_TIMER_CTRL);
	wire ptick      = (pre_r == pre_last);
	wire at_full    = (count_r == `TIMER_FULL);
	wire set_run    = ((auto_trigger_source_sel == `TRIG_OVP) && ext_edge_trigger_en
	                   && ovp_rise && !conversion_busy)
	                  || ((auto_trigger_source_sel == `TRIG_START) && start_rise);

	// Overvoltage comes from another block, so it is synchronised before its edge is taken
	level_sync2 ovp_sync_i (
		.mclk     (mclk),
		.srst     (srst),
		.async_in (overvoltage_event),
		.sync_out (ovp_sync)
	);

	edge_pulse #(
		.IDLE (1'b0)
	) ovp_edge_i (
		.mclk  (mclk),
		.srst  (srst),
		.level (ovp_sync),
		.rise  (ovp_rise),
		.fall  ()
	);

	// Start bit is a register of this clock, so no synchroniser in front of it
	edge_pulse #(
		.IDLE (1'b0)
	) start_edge_i (
		.mclk  (mclk),
		.srst  (srst),
		.level (auto_conv_start_bit),
		.rise  (start_rise),
		.fall  (start_fall)
	);

	always @* begin
		pre_last = timer_prescale_sel ? `PRE_DIV8_LAST : `PRE_DIV4_LAST;
		ovf_nxt  = timer_run_flag && ptick && at_full;
	end

	// Register writes
	always @(posedge mclk) begin
		if (srst) begin
			preload_high_byte       <= `RESET_BYTE;
			preload_low_byte        <= `RESET_BYTE;
			low_buf_r               <= `RESET_BYTE;
			ext_edge_trigger_en     <= 1'b0;
			timer_prescale_sel      <= 1'b0;
			auto_trigger_source_sel <= 2'h0;
			dual_channel_mode_en    <= 1'b0;
			auto_conv_start_bit     <= 1'b0;
			reference_source_sel    <= 2'h0;
			gain_amp_enable         <= 1'b0;
			gain_amp_gain_sel       <= 2'h0;
			gain_amp_input_sel      <= 2'h0;
			input_sel_r             <= 8'h00;
			conv_clock_div_sel      <= 3'h0;
			ch1_sel_r               <= 5'h00;
			ch2_sel_r               <= 5'h00;
			pin_analog_r            <= 8'h00;
		end else begin
			if (rd && (addr == `REG_PRELOAD_HI))
				low_buf_r <= preload_low_byte;
			if (wr) begin
				case (addr)
				`REG_TIMER_CTRL: begin
					ext_edge_trigger_en <= wdata[`TC_EXT_BIT];
					timer_prescale_sel  <= wdata[`TC_PSC_BIT];
				end
				`REG_PRELOAD_HI: begin
					preload_high_byte <= wdata;
					preload_low_byte  <= low_buf_r;
				end
				`REG_PRELOAD_LO: low_buf_r <= wdata;
				`REG_TRIG_CFG: begin
					auto_trigger_source_sel <= wdata[7:6];
					dual_channel_mode_en    <= wdata[`TRIG_DUAL_BIT];
				end
				`REG_AUTO_START: auto_conv_start_bit <= wdata[`AUTO_GO_BIT];
				`REG_REF_AMP: begin
					gain_amp_enable      <= wdata[`AMP_EN_BIT];
					gain_amp_gain_sel    <= wdata[5:4];
					gain_amp_input_sel   <= wdata[3:2];
					reference_source_sel <= wdata[1:0];
				end
				`REG_INPUT_SEL:  input_sel_r        <= wdata;
				`REG_CLK_SEL:    conv_clock_div_sel <= wdata[2:0];
				`REG_CH1_SEL:    ch1_sel_r          <= wdata[4:0];
				`REG_CH2_SEL:    ch2_sel_r          <= wdata[4:0];
				`REG_PIN_ANALOG: pin_analog_r       <= wdata;
				default: ;
				endcase
			end
		end
	end

	// Trigger timer; a hardware set beats a software clear in the same cycle
	always @(posedge mclk) begin
		if (srst) begin
			timer_run_flag <= 1'b0;
			pre_r          <= 3'h0;
			count_r        <= 16'h0000;
			timer_overflow <= 1'b0;
		end else begin
			timer_overflow <= ovf_nxt;
			if (set_run)
				timer_run_flag <= 1'b1;
			else if (ovf_nxt && (auto_trigger_source_sel == `TRIG_OVP))
				timer_run_flag <= 1'b0;
			else if (start_fall && (auto_trigger_source_sel == `TRIG_START))
				timer_run_flag <= 1'b0;
			else if (wr_ctrl && !wdata[`TC_RUN_BIT])
				timer_run_flag <= 1'b0;
			if (!timer_run_flag) begin
				pre_r   <= 3'h0;
				count_r <= {preload_high_byte, preload_low_byte};
			end else if (ptick) begin
				pre_r <= 3'h0;
				if (at_full)
					count_r <= {preload_high_byte, preload_low_byte};
				else
					count_r <= count_r + 16'h0001;
			end else begin
				pre_r <= pre_r + 3'h1;
			end
		end
	end

	// Converter clock divider and conversion phases
	always @* begin
		div_last = 7'h7F >> (3'h7 - conv_clock_div_sel);
		tick_nxt = (div_r == div_last);
	end

	always @(posedge mclk) begin
		if (srst) begin
			div_r           <= 7'h00;
			conv_clk_tick   <= 1'b0;
			phase_r         <= 5'h00;
			conversion_busy <= 1'b0;
			conv_sampling   <= 1'b0;
			conv_done       <= 1'b0;
		end else begin
			div_r         <= tick_nxt ? 7'h00 : div_r + 7'h01;
			conv_clk_tick <= tick_nxt;
			conv_done     <= 1'b0;
			if (!conversion_busy) begin
				if (conv_start) begin
					conversion_busy <= 1'b1;
					conv_sampling   <= 1'b1;
					phase_r         <= 5'h00;
				end
			end else if (tick_nxt) begin
				phase_r <= phase_r + 5'h01;
				if (phase_r == `SAMPLE_TICKS - 5'h01)
					conv_sampling <= 1'b0;
				if (phase_r == `CONV_TICKS - 5'h01) begin
					conversion_busy <= 1'b0;
					conv_done       <= 1'b1;
				end
			end
		end
	end

	// Input routing decode
	always @* begin
		src      = input_sel_r[7:4];
		dsel     = conv_channel ? ch2_sel_r : ch1_sel_r;
		chan_nxt = 3'h0;
		ext_nxt  = 1'b0;
		sig_nxt  = `SIG_AVSS;
		use_pin  = 1'b0;
		if (dual_channel_mode_en) begin
			use_pin  = dsel[`CH_SRC_BIT];
			if (dsel[`CH_SRC_BIT]) begin
				ext_nxt  = !dsel[3];
				chan_nxt = dsel[2:0];
			end else begin
				case (dsel[3:0])
				4'h1: sig_nxt = `SIG_AVDD2;
				4'h2: sig_nxt = `SIG_AVDD4;
				4'h3: sig_nxt = `SIG_VVR;
				4'h4: sig_nxt = `SIG_VVR2;
				4'h5: sig_nxt = `SIG_VVR4;
				4'h6, 4'h7, 4'h8: sig_nxt = `SIG_AVSS;
				4'h9: sig_nxt = `SIG_TSO;
				default: sig_nxt = `SIG_AVDD;
				endcase
			end
		end else begin
			case (src)
			4'h0, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF: begin
				use_pin  = 1'b1;
				ext_nxt  = !input_sel_r[3];
				chan_nxt = input_sel_r[2:0];
			end
			4'h1: sig_nxt = `SIG_AVDD;
			4'h2: sig_nxt = `SIG_AVDD2;
			4'h3: sig_nxt = `SIG_AVDD4;
			4'h5: sig_nxt = `SIG_VVR;
			4'h6: sig_nxt = `SIG_VVR2;
			4'h7: sig_nxt = `SIG_VVR4;
			4'hB: sig_nxt = `SIG_TSO;
			default: sig_nxt = `SIG_AVSS;
			endcase
		end
	end

	// A pin source with a floating channel must close no internal switch either
	onehot8 pin_switch_i (
		.en  (ext_nxt),
		.idx (chan_nxt),
		.sel (pin_onehot)
	);

	onehot8 sig_switch_i (
		.en  (!use_pin),
		.idx (sig_nxt),
		.sel (sig_onehot)
	);

	// Routing outputs; pin and internal path never both closed
	always @(posedge mclk) begin
		if (srst) begin
			an_pin_connect      <= 8'h00;
			int_sig_connect     <= 8'h00;
			pin_analog_mode     <= 8'h00;
			ref_sel_supply      <= 1'b1;
			ref_sel_pin         <= 1'b0;
			ref_sel_amp         <= 1'b0;
			amp_ref_pin_connect <= 1'b0;
		end else begin
			an_pin_connect  <= pin_onehot;
			int_sig_connect <= sig_onehot;
			pin_analog_mode <= pin_analog_r;
			ref_sel_supply  <= (reference_source_sel == `REF_SUPPLY);
			ref_sel_pin     <= (reference_source_sel == `REF_PIN);
			ref_sel_amp     <= reference_source_sel[1];
			amp_ref_pin_connect <= reference_source_sel[1] && gain_amp_enable
			                       && (gain_amp_input_sel == `AMP_IN_PIN);
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always @(posedge mclk) begin
		if (srst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
			`REG_TIMER_CTRL: rdata <= {3'h0, timer_run_flag, 2'h0,
			                           ext_edge_trigger_en, timer_prescale_sel};
			`REG_PRELOAD_HI: rdata <= preload_high_byte;
			`REG_PRELOAD_LO: rdata <= low_buf_r;
			`REG_TRIG_CFG:   rdata <= {auto_trigger_source_sel, dual_channel_mode_en, 5'h00};
			`REG_AUTO_START: rdata <= {auto_conv_start_bit, 7'h00};
			`REG_REF_AMP:    rdata <= {gain_amp_enable, 1'b0, gain_amp_gain_sel,
			                           gain_amp_input_sel, reference_source_sel};
			`REG_INPUT_SEL:  rdata <= input_sel_r;
			`REG_CLK_SEL:    rdata <= {5'h00, conv_clock_div_sel};
			`REG_CH1_SEL:    rdata <= {3'h0, ch1_sel_r};
			`REG_CH2_SEL:    rdata <= {3'h0, ch2_sel_r};
			`REG_STATUS:     rdata <= {6'h00, timer_run_flag, conversion_busy};
			`REG_PIN_ANALOG: rdata <= pin_analog_r;
			default:         rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule

// Two flip-flop synchroniser; only the second stage may be read
module level_sync2 (
	input  wire mclk,
	input  wire srst,
	input  wire async_in,
	output reg  sync_out
);
	reg meta_r;

	always @(posedge mclk) begin
		if (srst) begin
			meta_r   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// Rise and fall pulses of a level; the delay stage resets to the idle level,
// so the release of reset never shows a false edge
module edge_pulse #(
	parameter [0:0] IDLE = 1'b0
) (
	input  wire mclk,
	input  wire srst,
	input  wire level,
	output wire rise,
	output wire fall
);
	reg last_r;

	assign rise = level & ~last_r;
	assign fall = ~level & last_r;

	always @(posedge mclk) begin
		if (srst)
			last_r <= IDLE;
		else
			last_r <= level;
	end
endmodule

// One-hot switch enables from a three-bit index, all open when disabled
module onehot8 (
	input  wire       en,
	input  wire [2:0] idx,
	output wire [7:0] sel
);
	assign sel = en ? (8'h01 << idx) : 8'h00;
endmodule

// file: ovp_source.sv
// Over-voltage event source model
`timescale 1ns/10ps
module ovp_source (
	input  wire logic mclk,
	input  wire logic fire,
	output logic      overvoltage_event
);
	initial overvoltage_event = 1'b0;
	// Asynchronous level, moved off the clock grid; held long enough for the synchroniser
	always @(posedge mclk) begin
		if (fire) begin
			#3 overvoltage_event = 1'b1;
			repeat (4) @(posedge mclk);
			#3 overvoltage_event = 1'b0;
		end
	end
endmodule

// file: test_adc_trigger_input_ctrl.sv
// Self-checking bench for the converter trigger and input control block
`timescale 1ns/10ps
module test_adc_trigger_input_ctrl;
	logic       mclk, srst, wr, rd, conv_start, conv_channel, fire;
	logic [3:0] addr;
	logic [7:0] wdata;
	wire  [7:0] rdata, an_pin_connect, int_sig_connect, pin_analog_mode;
	wire        overvoltage_event, timer_overflow, conv_clk_tick, conv_sampling, conversion_busy;
	wire        conv_done, ref_sel_supply, ref_sel_pin, ref_sel_amp, amp_ref_pin_connect;
	wire        gain_amp_enable;
	wire  [1:0] gain_amp_gain_sel, gain_amp_input_sel;
	int         err_total, checks, cyc, n, m, a, b, c, d;
	adc_trigger_input_ctrl adc_trigger_input_ctrl_i (.mclk, .srst, .addr, .wdata, .wr, .rd, .rdata,
		.overvoltage_event, .conv_start, .conv_channel, .timer_overflow, .conv_clk_tick,
		.conv_sampling, .conversion_busy, .conv_done, .ref_sel_supply, .ref_sel_pin, .ref_sel_amp,
		.amp_ref_pin_connect, .gain_amp_enable, .gain_amp_gain_sel, .gain_amp_input_sel,
		.an_pin_connect, .int_sig_connect, .pin_analog_mode);
	ovp_source ovp_source_i (.mclk, .fire, .overvoltage_event);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;
	task automatic conclude;
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] ad, input logic [7:0] dt);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= ad;
		wdata <= dt;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] ad, input logic [7:0] exp);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		chk(rdata, exp);
	endtask
	// Routing outputs follow their register one cycle after the write lands
	task automatic rt(input logic [3:0] ad, input logic [7:0] dt, input logic [15:0] exp);
		wreg(ad, dt);
		repeat (2) @(negedge mclk);
		chk({an_pin_connect, int_sig_connect}, exp);
	endtask
	task automatic go;
		@(posedge mclk);
		conv_start <= 1'b1;
		@(posedge mclk);
		conv_start <= 1'b0;
	endtask
	task automatic bump;
		@(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (10) @(posedge mclk);
	endtask
	task automatic wait_ovf(output int at);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (timer_overflow !== 1'b1 && n < 3000);
		chk(n < 3000, 1);
		at = cyc;
	endtask
	// Divider free-runs, so the first tick after a setting change lands anywhere within 128 cycles
	task automatic conv_len(input int k);
		wreg(4'h7, 8'(k));
		d = 1 << k;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (conv_clk_tick !== 1'b1 && n < 300);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (conv_clk_tick !== 1'b1 && n < 300);
		chk(n, d);
		// Conversions only at the slow settings that keep the converter period legal
		if (k >= 6) begin
			go;
			n = 0;
			m = 0;
			do begin
				@(negedge mclk);
				n += conversion_busy;
				m += conv_sampling;
			end while (conversion_busy === 1'b1 && n < 3000);
			chk(n >= 15 * d && n <= 17 * d, 1);
			chk(m >= 3 * d && m <= 5 * d, 1);
		end
	endtask
	function automatic logic [15:0] route(input logic dual, input logic [3:0] s, input logic [3:0] ch);
		logic [2:0] k;
		logic       pin;
		pin = dual ? s[0] : (s == 0 || s == 4 || s >= 12);
		if (pin) return {(ch < 8) ? 8'h01 << ch[2:0] : 8'h00, 8'h00};
		if (dual) k = (ch >= 10) ? 3'h0 : (ch >= 6 && ch <= 8) ? 3'h6 : (ch == 9) ? 3'h7 : ch[2:0];
		else k = (s >= 8 && s <= 10) ? 3'h6 : (s == 11) ? 3'h7 : (s >= 5) ? 3'(s - 2) : 3'(s - 1);
		return {8'h00, 8'h01 << k};
	endfunction
	initial begin
		{srst, wr, rd, conv_start, conv_channel, fire} = 6'b100000;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		chk({ref_sel_supply, ref_sel_pin, ref_sel_amp}, 3'b100);
		rreg(4'h1, 8'h00);
		rreg(4'h2, 8'h00);
		rreg(4'hF, 8'h00);
		wreg(4'h2, 8'h34);
		wreg(4'h1, 8'h12);
		rreg(4'h1, 8'h12);
		rreg(4'h2, 8'h34);
		wreg(4'h2, 8'h56);
		rreg(4'h1, 8'h12);
		rreg(4'h2, 8'h34);
		wreg(4'h2, 8'hF0);
		wreg(4'h1, 8'hFF);
		wreg(4'h3, 8'h80);
		for (int p = 0; p < 2; p++) begin
			wreg(4'h0, 8'(p));
			wreg(4'h4, 8'h00);
			wreg(4'h4, 8'h80);
			wait_ovf(a);
			wait_ovf(b);
			chk(16'(b - a), 16'(64 << p));
		end
		wreg(4'h2, 8'hF8);
		wreg(4'h1, 8'hFF);
		wait_ovf(c);
		wait_ovf(d);
		chk(16'(c - b), 16'd128);
		chk(16'(d - c), 16'd64);
		rreg(4'hA, 8'h02);
		wreg(4'h4, 8'h00);
		repeat (3) @(posedge mclk);
		rreg(4'hA, 8'h00);
		wreg(4'h0, 8'h10);
		rreg(4'hA, 8'h00);
		wreg(4'h3, 8'h40);
		bump;
		rreg(4'hA, 8'h00);
		wreg(4'h0, 8'h02);
		bump;
		rreg(4'hA, 8'h02);
		wait_ovf(a);
		repeat (3) @(posedge mclk);
		rreg(4'hA, 8'h00);
		wreg(4'h7, 8'h06);
		go;
		bump;
		rreg(4'hA, 8'h01);
		repeat (1100) @(posedge mclk);
		rreg(4'hA, 8'h00);
		for (int s = 0; s < 4; s += 3) begin
			wreg(4'h3, 8'(s << 6));
			bump;
			wreg(4'h4, 8'h00);
			wreg(4'h4, 8'h80);
			rreg(4'hA, 8'h00);
		end
		// Converter clock period at every divider setting, conversion length at settings 6 and 7 only
		for (int k = 0; k < 8; k++) conv_len(k);
		for (int i = 0; i < 4; i++) begin
			wreg(4'h5, {2'b10, i[1:0], 2'b00, i[1:0]});
			repeat (2) @(negedge mclk);
			chk({ref_sel_supply, ref_sel_pin, ref_sel_amp, amp_ref_pin_connect, gain_amp_enable,
				gain_amp_gain_sel, gain_amp_input_sel},
				{3'b100 >> ((i > 1) ? 2 : i), i > 1, 1'b1, i[1:0], 2'b00});
		end
		wreg(4'h5, 8'h86);
		repeat (2) @(negedge mclk);
		chk(amp_ref_pin_connect, 0);
		wreg(4'h3, 8'h00);
		for (int i = 0; i < 16; i++) rt(4'h6, {i[3:0], 4'h5}, route(0, i[3:0], 4'h5));
		rt(4'h6, 8'h4C, route(0, 4'h4, 4'hC));
		wreg(4'h3, 8'h20);
		for (int i = 0; i < 32; i++) rt(4'h8, 8'(i), route(1, {3'h0, i[4]}, i[3:0]));
		@(posedge mclk);
		conv_channel <= 1'b1;
		rt(4'h9, 8'h12, route(1, 4'h1, 4'h2));
		wreg(4'hB, 8'hA5);
		rreg(4'hB, 8'hA5);
		chk(pin_analog_mode, 8'hA5);
		conclude;
	end
	initial begin
		repeat (30000) @(posedge mclk);
		err_total++;
		conclude;
	end
endmodule
